// File: rtl/malc_pkg.sv
// Purpose: shared constants and types of the max address limit command block
// Assumes: 8-bit register port, one clock at 50 MHz
// Notes:   identify words are held as one packed struct of geometry fields
package malc_pkg;

  // ****************************************************************
  // register offsets on the plain register port
  // ****************************************************************
  localparam logic [3:0] OFS_ERROR    = 4'h1; // error_flags, read only
  localparam logic [3:0] OFS_COUNT    = 4'h2; // sector count input
  localparam logic [3:0] OFS_LOW      = 4'h3; // limit_low_byte
  localparam logic [3:0] OFS_MID      = 4'h4; // limit_mid_byte
  localparam logic [3:0] OFS_HIGH     = 4'h5; // limit_high_byte
  localparam logic [3:0] OFS_UNIT     = 4'h6; // unit_select_and_top_bits
  localparam logic [3:0] OFS_CMD      = 4'h7; // write: command, read: command_status
  localparam logic [3:0] OFS_CONFIG   = 4'h8; // feature configuration
  localparam logic [3:0] OFS_ID_INDEX = 4'h9; // identify word index
  localparam logic [3:0] OFS_ID_LO    = 4'ha; // identify word, low byte
  localparam logic [3:0] OFS_ID_HI    = 4'hb; // identify word, high byte

  // ****************************************************************
  // command codes and field positions
  // ****************************************************************
  localparam logic [7:0] CMD_SET_MAX    = 8'hf9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;
  localparam int         ERR_ABORT_BIT  = 2;
  localparam int         ERR_IDNF_BIT   = 4;
  localparam int         ST_BUSY_BIT    = 7;
  localparam int         ST_READY_BIT   = 6;
  localparam int         ST_ERR_BIT     = 0;
  localparam int         UNIT_LBA_BIT   = 6;
  localparam int         COUNT_KEEP_BIT = 0;
  localparam int         CFG_CHS_BIT    = 0;
  localparam int         CFG_ENABLE_BIT = 1;
  localparam logic [1:0] CFG_RESET      = 2'h3;

  // ****************************************************************
  // geometry limits
  // ****************************************************************
  localparam logic [15:0] CYL_CAP    = 16'h3fff;      // 16,383
  localparam logic [15:0] WORD_CAP   = 16'hffff;      // 65,535
  localparam logic [31:0] CHS_CAP    = 32'h00fbfc10;  // 16,514,064
  localparam logic [5:0]  ID_W1      = 6'h01;
  localparam logic [5:0]  ID_W3      = 6'h03;
  localparam logic [5:0]  ID_W6      = 6'h06;
  localparam logic [5:0]  ID_W54     = 6'h36;
  localparam logic [5:0]  ID_W55     = 6'h37;
  localparam logic [5:0]  ID_W56     = 6'h38;
  localparam logic [5:0]  ID_W57     = 6'h39;
  localparam logic [5:0]  ID_W58     = 6'h3a;
  localparam logic [5:0]  ID_W60     = 6'h3c;
  localparam logic [5:0]  ID_W61     = 6'h3d;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {MALC_BOOT, MALC_IDLE, MALC_EXEC} malc_state_type;

  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w3;
    logic [15:0] w6;
    logic [15:0] w54;
    logic [15:0] w55;
    logic [15:0] w56;
    logic [31:0] w5758;
    logic [31:0] w6061;
  } malc_words_type;

  typedef struct packed {
    malc_state_type st;
    logic [7:0]     count;
    logic [7:0]     low;
    logic [7:0]     mid;
    logic [7:0]     high;
    logic [7:0]     unit;
    logic [7:0]     err;
    logic           busy;
    logic           ready;
    logic           err_st;
    logic           native_ok;
    logic           nv_used;
    logic [1:0]     cfg;
    logic [5:0]     id_index;
    malc_words_type words;
    logic [27:0]    max_lba;
    logic [7:0]     rdata;
    logic           acc_done;
    logic           acc_reject;
    logic           nv_we;
    logic [27:0]    nv_data;
  } malc_regs_type;

endpackage

// File: rtl/malc_top.sv
// Purpose: device side of the set max address command with identify upkeep
// Assumes: host task-file accesses arrive on a plain synchronous port
// Notes:   the non-volatile limit lives outside; this block reads it at boot
//          hw_reset is honoured only while idle, never in the middle of a command
//
// Function
// - success returns limit in force in registers
// - success clears busy, fault, request, error
// - abort if unsupported or above capacity
// - abort CHS limit with cylinder above 16383
// - abort unless preceded by native max read
// - second non-volatile set gives id-not-found
// - error clears busy, sets ready and error
// - CHS: word1 is min(cyl+1, 16383)
// - CHS: capacity is words 1*3*6
// - CHS: word54 from clamped capacity, capped 65535
// - CHS: words 58:57 are 54*55*56
// - LBA: capacity is max LBA plus one
// - LBA large without CHS zeroes geometry words
// - LBA with CHS: word1 derived or 16383
// - LBA with CHS: word54 derived or 16383
// - LBA with CHS: words 58:57 are product
// - accesses above the limit get id-not-found
// - failed command leaves identify words unchanged
// - keep bit selects persistent or reverting limit
// - addressing bit selects LBA or CHS limit
module malc_top
  import malc_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h1312cff,
  parameter logic [15:0] HEADS          = 16'h0010,
  parameter logic [15:0] SECTORS        = 16'h003f
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        hw_reset,
  input  wire logic [27:0] nv_limit_in,
  output logic             nv_limit_we,
  output logic      [27:0] nv_limit_out,
  input  wire logic        acc_req,
  input  wire logic [27:0] acc_lba,
  output logic             acc_done,
  output logic             acc_reject
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (HEADS == 16'h0000 || HEADS > 16'h0010 || SECTORS == 16'h0000 ||
      SECTORS > 16'h00ff) begin : g_bad_geometry
    $error("malc_top: geometry parameters out of range");
  end
  if (NATIVE_MAX_LBA == 28'h0000000) begin : g_bad_native
    $error("malc_top: native maximum address must not be zero");
  end

  // capacity one above the native top address; the CHS capacity check uses it
  localparam logic [31:0] NATIVE_CAP = {4'h0, NATIVE_MAX_LBA} + 32'h00000001;

  // default geometry words before any limit is applied
  localparam malc_words_type DEFAULT_WORDS = '{
    w1: CYL_CAP, w3: HEADS, w6: SECTORS, w54: CYL_CAP, w55: HEADS,
    w56: SECTORS, w5758: 32'h0, w6061: NATIVE_CAP};

  // the whole state of the block lives in one register struct
  malc_regs_type r_q;
  malc_regs_type r_d;

  // ****************************************************************
  // identify word recomputation
  // ****************************************************************
  // divisions are combinational; one busy cycle covers them at 50 MHz
  function automatic malc_words_type calc_words(
    input logic           lba_mode,
    input logic [27:0]    lba,
    input logic [15:0]    cyl,
    input logic           chs_sup,
    input malc_words_type w
  );
    malc_words_type n;
    logic [47:0]    prod;
    logic [31:0]    cap;
    logic [31:0]    capc;
    logic [31:0]    hs55;
    logic [31:0]    hs36;
    logic [31:0]    q;
    n    = w;
    // sectors per cylinder of the current and of the default geometry
    hs55 = {16'h0, w.w55} * {16'h0, w.w56};
    hs36 = {16'h0, w.w3} * {16'h0, w.w6};
    // CHS path: the cylinder count drives capacity and word 54
    if (!lba_mode) begin
      n.w1 = (cyl >= CYL_CAP) ? CYL_CAP : cyl + 16'h0001;
      prod = {32'h0, n.w1} * {32'h0, w.w3} * {32'h0, w.w6};
      cap  = prod[31:0];
      capc = (cap > CHS_CAP) ? CHS_CAP : cap;
      q    = (hs55 == 32'h0) ? 32'h0 : capc / hs55;
      n.w54 = (q > {16'h0, WORD_CAP}) ? WORD_CAP : q[15:0];
    end else begin
      // LBA path: capacity drives both cylinder counts
      cap = {4'h0, lba} + 32'h00000001;
      if (cap >= CHS_CAP) begin
        n.w1  = CYL_CAP;
        n.w54 = CYL_CAP;
      end else begin
        q     = (hs36 == 32'h0) ? 32'h0 : cap / hs36;
        n.w1  = (q > {16'h0, WORD_CAP}) ? WORD_CAP : q[15:0];
        q     = (hs55 == 32'h0) ? 32'h0 : cap / hs55;
        n.w54 = (q > {16'h0, WORD_CAP}) ? WORD_CAP : q[15:0];
      end
    end
    // product of the final word 54 with the unchanged heads and sectors
    n.w6061 = cap;
    prod    = {32'h0, n.w54} * {32'h0, n.w55} * {32'h0, n.w56};
    n.w5758 = prod[31:0];
    // a large capacity has no geometry form without CHS support
    if (lba_mode && !chs_sup && cap > CHS_CAP) begin
      n.w1    = 16'h0;
      n.w3    = 16'h0;
      n.w6    = 16'h0;
      n.w54   = 16'h0;
      n.w55   = 16'h0;
      n.w56   = 16'h0;
      n.w5758 = 32'h0;
    end
    return n;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic           lba_mode;
    logic [27:0]    req_lba;
    logic [15:0]    req_cyl;
    logic [27:0]    boot_lba;
    malc_words_type nw;
    logic [7:0]     e;
    // the limit is decoded exactly as the host left it in the task file
    lba_mode = r_q.unit[UNIT_LBA_BIT];
    req_lba  = {r_q.unit[3:0], r_q.high, r_q.mid, r_q.low};
    req_cyl  = {r_q.high, r_q.mid};
    boot_lba = (nv_limit_in > NATIVE_MAX_LBA) ? NATIVE_MAX_LBA : nv_limit_in;
    nw       = calc_words(lba_mode, req_lba, req_cyl, r_q.cfg[CFG_CHS_BIT], r_q.words);
    e        = 8'h00;
    // hold all state, then drop the one-cycle pulses
    r_d            = r_q;
    r_d.rdata      = 8'h00;
    r_d.acc_done   = 1'b0;
    r_d.acc_reject = 1'b0;
    r_d.nv_we      = 1'b0;

    // limit check for media accesses
    if (acc_req) begin
      r_d.acc_done   = 1'b1;
      r_d.acc_reject = (acc_lba > r_q.max_lba);
    end

    unique case (r_q.st)
      MALC_BOOT: begin
        // reverts to the stored limit at power-on and hardware reset
        r_d.words   = calc_words(1'b1, boot_lba, 16'h0, r_q.cfg[CFG_CHS_BIT],
                                 DEFAULT_WORDS);
        r_d.max_lba = boot_lba;
        r_d.busy    = 1'b0;
        r_d.ready   = 1'b1;
        r_d.st      = MALC_IDLE;
      end
      MALC_IDLE: begin
        // writes are taken only here, so writes during boot or exec are dropped
        if (reg_wr) begin
          unique case (reg_addr)
            OFS_COUNT:    r_d.count    = reg_wdata;
            OFS_LOW:      r_d.low      = reg_wdata;
            OFS_MID:      r_d.mid      = reg_wdata;
            OFS_HIGH:     r_d.high     = reg_wdata;
            OFS_UNIT:     r_d.unit     = reg_wdata;
            OFS_CONFIG:   r_d.cfg      = reg_wdata[1:0];
            OFS_ID_INDEX: r_d.id_index = reg_wdata[5:0];
            OFS_CMD: begin
              r_d.err    = 8'h00;
              r_d.err_st = 1'b0;
              if (reg_wdata == CMD_SET_MAX) begin
                r_d.busy  = 1'b1;
                r_d.ready = 1'b0;
                r_d.st    = MALC_EXEC;
              end else if (reg_wdata == CMD_READ_NATIVE) begin
                // native maximum in the mode the host selected
                if (r_q.unit[UNIT_LBA_BIT]) begin
                  r_d.low  = NATIVE_MAX_LBA[7:0];
                  r_d.mid  = NATIVE_MAX_LBA[15:8];
                  r_d.high = NATIVE_MAX_LBA[23:16];
                  r_d.unit = {r_q.unit[7:4], NATIVE_MAX_LBA[27:24]};
                end else begin
                  // last cylinder below the identify cap, last head, last sector
                  r_d.low  = SECTORS[7:0];
                  r_d.mid  = 8'hfe;
                  r_d.high = CYL_CAP[15:8];
                  r_d.unit = {r_q.unit[7:4], 4'(HEADS - 16'h0001)};
                end
                r_d.native_ok = 1'b1;
              end else begin
                // any other command breaks the read-then-set pairing
                r_d.native_ok = 1'b0;
              end
            end
            default: ;
          endcase
        end
        // hardware reset wins over a command in the same cycle: the boot pass
        // must start from a clean native flag and a clean use count
        if (hw_reset) begin
          r_d.nv_used   = 1'b0;
          r_d.native_ok = 1'b0;
          r_d.busy      = 1'b1;
          r_d.st        = MALC_BOOT;
        end
      end
      MALC_EXEC: begin
        // error checks; all failures skip the word update
        if (!r_q.cfg[CFG_ENABLE_BIT] || !r_q.native_ok) begin
          e[ERR_ABORT_BIT] = 1'b1;
        end
        if (lba_mode && req_lba > NATIVE_MAX_LBA) begin
          e[ERR_ABORT_BIT] = 1'b1;
        end
        if (!lba_mode && (req_cyl > CYL_CAP || !r_q.cfg[CFG_CHS_BIT] ||
                          nw.w6061 > NATIVE_CAP)) begin
          e[ERR_ABORT_BIT] = 1'b1;
        end
        // a second persistent set is refused even when all else is legal
        if (r_q.count[COUNT_KEEP_BIT] && r_q.nv_used) begin
          e[ERR_IDNF_BIT] = 1'b1;
        end
        // status follows the flags; abort and id-not-found may stand together
        r_d.err       = e;
        r_d.err_st    = (e != 8'h00);
        r_d.busy      = 1'b0;
        r_d.ready     = 1'b1;
        r_d.native_ok = 1'b0;
        // limit and words move only on success, so a failure leaves them alone
        if (e == 8'h00) begin
          r_d.words   = nw;
          r_d.max_lba = nw.w6061[27:0] - 28'h0000001;
          // only a persistent set reaches the store; a volatile one is lost at reset
          if (r_q.count[COUNT_KEEP_BIT]) begin
            r_d.nv_used = 1'b1;
            r_d.nv_we   = 1'b1;
            r_d.nv_data = nw.w6061[27:0] - 28'h0000001;
          end
          // limit registers keep the value now in force
          if (!lba_mode) begin
            r_d.high = nw.w1 == CYL_CAP && req_cyl > CYL_CAP ? 8'h3f : r_q.high;
          end
        end
        r_d.st = MALC_IDLE;
      end
      default: r_d.st = MALC_IDLE;
    endcase

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_ERROR: r_d.rdata = r_q.err;
        OFS_COUNT: r_d.rdata = r_q.count;
        OFS_LOW:   r_d.rdata = r_q.low;
        OFS_MID:   r_d.rdata = r_q.mid;
        OFS_HIGH:  r_d.rdata = r_q.high;
        OFS_UNIT:  r_d.rdata = r_q.unit;
        OFS_CMD: begin
          r_d.rdata               = 8'h00; // fault and request always clear
          r_d.rdata[ST_BUSY_BIT]  = r_q.busy;
          r_d.rdata[ST_READY_BIT] = r_q.ready;
          r_d.rdata[ST_ERR_BIT]   = r_q.err_st;
        end
        OFS_CONFIG:   r_d.rdata = {6'h00, r_q.cfg};
        OFS_ID_INDEX: r_d.rdata = {2'h0, r_q.id_index};
        // identify words go out a byte at a time through the index register
        OFS_ID_LO:    r_d.rdata = id_word(r_q.id_index, r_q.words, 1'b0);
        OFS_ID_HI:    r_d.rdata = id_word(r_q.id_index, r_q.words, 1'b1);
        default:      r_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // identify word window
  // ****************************************************************
  function automatic logic [7:0] id_word(
    input logic [5:0]     idx,
    input malc_words_type w,
    input logic           hi
  );
    logic [15:0] v;
    // words outside this block's concern read as zero
    unique case (idx)
      ID_W1:   v = w.w1;
      ID_W3:   v = w.w3;
      ID_W6:   v = w.w6;
      ID_W54:  v = w.w54;
      ID_W55:  v = w.w55;
      ID_W56:  v = w.w56;
      ID_W57:  v = w.w5758[15:0];
      ID_W58:  v = w.w5758[31:16];
      ID_W60:  v = w.w6061[15:0];
      ID_W61:  v = w.w6061[31:16];
      default: v = 16'h0000;
    endcase
    return hi ? v[15:8] : v[7:0];
  endfunction

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset holds busy until the boot pass has loaded the stored limit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q          <= '0;
      r_q.st       <= MALC_BOOT;
      r_q.busy     <= 1'b1;
      r_q.cfg      <= CFG_RESET;
      r_q.unit     <= 8'ha0;
    end else begin
      r_q <= r_d;
    end
  end

  // every output is a register field, never a decode
  assign reg_rdata    = r_q.rdata;
  assign nv_limit_we  = r_q.nv_we;
  assign nv_limit_out = r_q.nv_data;
  assign acc_done     = r_q.acc_done;
  assign acc_reject   = r_q.acc_reject;

endmodule

// File: tb/malc_nv_model.sv
// Purpose: non-volatile limit store that sits beside the block
// Assumes: store pulse is one cycle, value taken on that edge
// Notes:   contents survive both reset inputs, like real storage
module malc_nv_model #(
  parameter logic [27:0] INIT = 28'h1312cff
) (
  input  wire logic        ref_clk,
  input  wire logic        nv_limit_we,
  input  wire logic [27:0] nv_limit_out,
  output logic      [27:0] nv_limit_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [27:0] mem = INIT;
  // no reset on purpose: a persistent limit must outlive every reset
  always_ff @(posedge ref_clk) begin
    if (nv_limit_we) mem <= nv_limit_out;
  end
  assign nv_limit_in = mem;
endmodule

// File: tb/malc_props.sv
// Purpose: port-level checks of the limit command block
// Assumes: one clock, async active-low reset
// Notes:   bound onto malc_top below
module malc_props
  import malc_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h1312cff
) (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        acc_req,
  input wire logic        acc_done,
  input wire logic        acc_reject,
  input wire logic        nv_limit_we,
  input wire logic [27:0] nv_limit_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_ACC_ANSWER: assert property (acc_req |=> acc_done)
    else $error("access check not answered");
  AST_ACC_QUIET: assert property (!acc_req |=> !acc_done && !acc_reject)
    else $error("access answer without request");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_STATUS_ZERO: assert property ((reg_rd && reg_addr == OFS_CMD) |=>
    (reg_rdata & 8'h3e) == 8'h00) else $error("status fault or request bit set");
  AST_ERR_BITS: assert property ((reg_rd && reg_addr == OFS_ERROR) |=>
    (reg_rdata & 8'heb) == 8'h00) else $error("unexpected error flag");
  AST_NV_PULSE: assert property (nv_limit_we |=> !nv_limit_we)
    else $error("store pulse too long");
  AST_NV_CAUSE: assert property (nv_limit_we |-> $past(reg_wr, 2) &&
    $past(reg_addr, 2) == OFS_CMD && $past(reg_wdata, 2) == CMD_SET_MAX)
    else $error("store without set command");
  AST_NV_RANGE: assert property (nv_limit_we |-> nv_limit_out <= NATIVE_MAX_LBA)
    else $error("stored limit above capacity");
endmodule
bind malc_top malc_props #(.NATIVE_MAX_LBA(NATIVE_MAX_LBA)) u_props (.ref_clk, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_done, .acc_reject,
  .nv_limit_we, .nv_limit_out);

// File: tb/malc_tb_top.sv
// Purpose: self-checking bench of the limit command block
// Assumes: geometry 16 heads, 63 sectors; configuration starts at 0x3
// Notes:   current heads and sectors are taken equal to the default ones
module malc_tb_top;
  import malc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [27:0] NAT = 28'h1312cff;
  localparam logic [15:0] HD = 16'h0010;
  localparam logic [15:0] SC = 16'h003f;
  localparam logic [5:0] IDS [10] = '{ID_W1, ID_W3, ID_W6, ID_W54, ID_W55, ID_W56,
                                      ID_W57, ID_W58, ID_W60, ID_W61};
  logic ref_clk, arst_n, reg_wr, reg_rd, hw_reset, acc_req, nv_limit_we, acc_done, acc_reject;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, b, lo;
  logic [27:0] nv_limit_in, nv_limit_out, acc_lba, v;
  logic [31:0] seed;
  int          error_cnt, check_count;
  malc_words_type cur;
  malc_top #(.NATIVE_MAX_LBA(NAT), .HEADS(HD), .SECTORS(SC)) dut (.ref_clk, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_reset, .nv_limit_in,
    .nv_limit_we, .nv_limit_out, .acc_req, .acc_lba, .acc_done, .acc_reject);
  malc_nv_model #(.INIT(NAT)) u_nv (.ref_clk, .nv_limit_we, .nv_limit_out, .nv_limit_in);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // identify words after a successful limit; hs is the sectors per cylinder
  function automatic malc_words_type calc(logic lba, logic [27:0] l, logic chs);
    malc_words_type w;
    logic [31:0] hs, cap, t;
    w = '0;
    w.w3 = HD; w.w6 = SC; w.w55 = HD; w.w56 = SC;
    hs = 32'(HD) * 32'(SC);
    if (lba) begin
      cap = {4'h0, l} + 32'h1;
      t = (cap >= CHS_CAP) ? 32'(CYL_CAP) : cap / hs;
      if (t > 32'(WORD_CAP)) t = 32'(WORD_CAP);
      w.w1 = t[15:0];
    end else begin
      t = (l[23:8] >= CYL_CAP) ? 32'(CYL_CAP) : 32'(l[23:8]) + 32'h1;
      w.w1 = t[15:0];
      cap = t * hs;
      t = ((cap > CHS_CAP) ? CHS_CAP : cap) / hs;
      if (t > 32'(WORD_CAP)) t = 32'(WORD_CAP);
    end
    w.w54 = t[15:0];
    w.w5758 = 32'(w.w54) * hs;
    w.w6061 = cap;
    if (lba && !chs && cap > CHS_CAP) begin
      w = '0;
      w.w6061 = cap;
    end
    return w;
  endfunction
  function automatic logic [15:0] wsel(int i);
    logic [16*10-1:0] f;
    f = {cur.w6061, cur.w5758, cur.w56, cur.w55, cur.w54, cur.w6, cur.w3, cur.w1};
    return f[16*i +: 16];
  endfunction
  // ****************************************************************
  // bus tasks and compares
  // ****************************************************************
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 b = reg_rdata;
  endtask
  task automatic cmd(logic [7:0] c);
    wr(OFS_CMD, c);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_CMD);
      if (b[ST_BUSY_BIT] !== 1'b1) break;
    end
  endtask
  task automatic setmax(logic lba, logic [27:0] l, logic keep, logic pre);
    if (pre) cmd(CMD_READ_NATIVE);
    wr(OFS_COUNT, {7'h0, keep});
    wr(OFS_LOW, l[7:0]);
    wr(OFS_MID, l[15:8]);
    wr(OFS_HIGH, l[23:16]);
    wr(OFS_UNIT, {1'b1, lba, 2'b10, l[27:24]});
    cmd(CMD_SET_MAX);
  endtask
  task automatic outcome(logic [7:0] e);
    rd(OFS_ERROR);
    chk("error", e, b);
    rd(OFS_CMD);
    chk("status", {2'b01, 5'h0, |e}, b);
  endtask
  task automatic regback(logic [27:0] l);
    rd(OFS_LOW); chk("low", l[7:0], b);
    rd(OFS_MID); chk("mid", l[15:8], b);
    rd(OFS_HIGH); chk("high", l[23:16], b);
    rd(OFS_UNIT); chk("top", l[27:24], b[3:0]);
  endtask
  task automatic idchk();
    for (int i = 0; i < 10; i++) begin
      wr(OFS_ID_INDEX, {2'b00, IDS[i]});
      rd(OFS_ID_LO); lo = b;
      rd(OFS_ID_HI);
      chk("identify", wsel(i), {b, lo});
    end
  endtask
  task automatic acc(logic [27:0] l, logic rej);
    @(posedge ref_clk);
    acc_req <= 1'b1; acc_lba <= l;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    #1 chk("reject", {1'b1, rej}, {acc_done, acc_reject});
  endtask
  task automatic hwr();
    @(posedge ref_clk) hw_reset <= 1'b1;
    @(posedge ref_clk) hw_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    seed = 32'd26383; arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; hw_reset = 1'b0; acc_req = 1'b0; acc_lba = 28'h0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cur = calc(1'b1, NAT, 1'b1);
    setmax(1'b1, 28'h64, 1'b0, 1'b0); outcome(8'h04);
    idchk();
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? NAT : (i == 1) ? 28'd16514062 : (i == 2) ? 28'd16514063 : 28'(xs() % NAT);
      setmax(1'b1, v, 1'b0, 1'b1); outcome(8'h00);
      regback(v);
      cur = calc(1'b1, v, 1'b1); idchk();
      acc(v, 1'b0); acc(v + 28'h1, 1'b1);
    end
    cmd(CMD_READ_NATIVE); regback(NAT);
    setmax(1'b1, NAT + 28'h1, 1'b0, 1'b1); outcome(8'h04);
    setmax(1'b0, {4'h0, 16'd16384, 8'h01}, 1'b0, 1'b1); outcome(8'h04);
    idchk();
    for (int i = 0; i < 4; i++) begin
      v = {4'(HD - 16'h1), (i == 0) ? 16'd16383 : (i == 1) ? 16'd16382 : 16'(xs() % 16383),
           SC[7:0]};
      setmax(1'b0, v, 1'b0, 1'b1); outcome(8'h00);
      cur = calc(1'b0, v, 1'b1); idchk();
    end
    cmd(CMD_READ_NATIVE); regback({4'(HD - 16'h1), CYL_CAP - 16'h1, SC[7:0]});
    wr(OFS_CONFIG, 8'h01);
    setmax(1'b1, NAT, 1'b0, 1'b1); outcome(8'h04);
    wr(OFS_CONFIG, 8'h02);
    setmax(1'b1, NAT, 1'b0, 1'b1); outcome(8'h00);
    cur = calc(1'b1, NAT, 1'b0); idchk();
    wr(OFS_CONFIG, 8'h03);
    // geometry zeroed by the non-CHS limit comes back only through a boot pass
    hwr(); cur = calc(1'b1, NAT, 1'b1); idchk();
    v = 28'(xs() % NAT);
    setmax(1'b1, v, 1'b1, 1'b1); outcome(8'h00);
    chk("stored", v, u_nv.mem);
    cur = calc(1'b1, v, 1'b1);
    setmax(1'b1, NAT, 1'b1, 1'b1); rd(OFS_ERROR); chk("idnf", 1'b1, b[ERR_IDNF_BIT]);
    idchk();
    setmax(1'b1, NAT, 1'b0, 1'b1); outcome(8'h00);
    hwr(); idchk();
    acc(v + 28'h1, 1'b1);
    setmax(1'b1, NAT, 1'b1, 1'b1); outcome(8'h00);
    wrap_up();
  end
endmodule
